//--- rtl/tone_loopback_controller.sv
// Loopback control for a four-wire terminal repeater: manual and tone driven.
// Assumes option switches and the tone detector output are asynchronous
// levels; tone detector output is already qualified for frequency.
`timescale 1ns/1ns
`default_nettype none
module tone_loopback_controller #(
  parameter int TICK_CYCLES = loop_pkg::TICK_CYCLES,
  parameter int ACT_MS      = loop_pkg::ACT_MIN_MS,
  parameter int REL_MS      = loop_pkg::REL_MIN_MS,
  parameter int SHORT_MS    = loop_pkg::TMO_SHORT_MS,
  parameter int LONG_MS     = loop_pkg::TMO_LONG_MS
) (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic tone_detect,
  input  wire logic manual_loop_force,
  input  wire logic external_manual_loop_input,
  input  wire logic tone_loop_enable,
  input  wire logic loop_timeout_enable,
  input  wire logic timeout_long_select,
  input  wire logic terminal_busy_during_loop,
  output logic      loop_active,
  output logic      tone_loop_active,
  output logic      terminal_busy_out
);
  import loop_pkg::*;

  localparam logic [BURST_W-1:0] ACT_L   = BURST_W'(ACT_MS);
  localparam logic [BURST_W-1:0] REL_L   = BURST_W'(REL_MS);
  localparam logic [TMO_W-1:0]   SHORT_L = TMO_W'(SHORT_MS);
  localparam logic [TMO_W-1:0]   LONG_L  = TMO_W'(LONG_MS);
  localparam logic [BURST_W-1:0] BURST_MAX = '1;

  // Millisecond enable
  logic tick;

  tick_divider #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .tick    (tick)
  );

  // Two-flop synchronisers for all pin inputs except ref_clk and nrst; the two manual inputs are ORed first
  logic [5:0] meta_r;
  logic [5:0] sync_r;
  logic       tone_s;
  logic       manual_s;
  logic       tone_en_s;
  logic       tmo_en_s;
  logic       long_s;
  logic       bo_s;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r <= 6'h00;
      sync_r <= 6'h00;
    end
    else
    begin
      meta_r <= {tone_detect, manual_loop_force | external_manual_loop_input,
                 tone_loop_enable, loop_timeout_enable, timeout_long_select,
                 terminal_busy_during_loop};
      sync_r <= meta_r;
    end
  end

  assign {tone_s, manual_s, tone_en_s, tmo_en_s, long_s, bo_s} = sync_r;

  // Loop state, burst timer, timeout timer and outputs
  tone_state_type     st_r;
  tone_state_type     st_nxt;
  logic [BURST_W-1:0] burst_r;
  logic [BURST_W-1:0] burst_nxt;
  logic [TMO_W-1:0]   tmo_r;
  logic [TMO_W-1:0]   tmo_nxt;
  logic               tone_d_r;
  logic               burst_end;
  logic               rel_hit;
  logic               tmo_hit;
  logic               loop_nxt;
  logic               busy_nxt;

  assign burst_end = tone_d_r && !tone_s;
  assign rel_hit   = tone_s && (burst_r >= REL_L);
  assign tmo_hit   = tmo_en_s && (tmo_r >= (long_s ? LONG_L : SHORT_L));

  // Next-state logic
  always_comb
  begin
    st_nxt    = st_r;
    tmo_nxt   = tmo_r;
    // Burst length restarts from zero whenever tone is absent
    burst_nxt = '0;
    if (tone_s)
    begin
      burst_nxt = (tick && burst_r != BURST_MAX) ? burst_r + 1'b1 : burst_r;
    end
    case (st_r)
      ST_IDLE:
      begin
        tmo_nxt = '0;
        // Entry only at the end of a long burst, tone mode on
        if (burst_end && tone_en_s && !manual_s && burst_r >= ACT_L)
        begin
          st_nxt = ST_LOOPED;
        end
      end
      ST_LOOPED:
      begin
        if (tick && tmo_r != '1)
        begin
          tmo_nxt = tmo_r + 1'b1;
        end
        if (rel_hit && !manual_s)
        begin
          st_nxt = ST_DRAIN;
        end
        else if (tmo_hit)
        begin
          st_nxt = ST_IDLE;
        end
      end
      ST_DRAIN:
      begin
        // Rest of the release burst must not re-arm entry
        tmo_nxt = '0;
        if (!tone_s)
        begin
          st_nxt = ST_IDLE;
        end
      end
      default:
      begin
        st_nxt  = ST_IDLE;
        tmo_nxt = '0;
      end
    endcase
    loop_nxt = manual_s || (st_nxt == ST_LOOPED);
    busy_nxt = loop_nxt && bo_s;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r              <= ST_IDLE;
      burst_r           <= '0;
      tmo_r             <= '0;
      tone_d_r          <= 1'b0;
      loop_active       <= 1'b0;
      tone_loop_active  <= 1'b0;
      terminal_busy_out <= 1'b0;
    end
    else
    begin
      st_r              <= st_nxt;
      burst_r           <= burst_nxt;
      tmo_r             <= tmo_nxt;
      tone_d_r          <= tone_s;
      loop_active       <= loop_nxt;
      tone_loop_active  <= (st_nxt == ST_LOOPED);
      terminal_busy_out <= busy_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_burst_end;
    $past(tone_s) && !tone_s;
  endsequence

  sequence s_short_burst;
    s_burst_end and (burst_r < ACT_L) and (st_r == ST_IDLE);
  endsequence

  a_manual_holds: assert property (manual_s |=> loop_active)
    else $error("manual loop not holding loopback");

  a_manual_no_rel: assert property (
    (st_r == ST_LOOPED && manual_s && !tmo_hit) |=> st_r == ST_LOOPED)
    else $error("tone released a manual loop");

  a_tone_disabled: assert property (
    (st_r == ST_IDLE && !tone_en_s) |=> st_r != ST_LOOPED)
    else $error("tone entry while tone mode off");

  a_entry_cause: assert property (
    (st_r == ST_IDLE ##1 st_r == ST_LOOPED)
    |-> $past(burst_end) && $past(burst_r) >= ACT_L ##1 tone_loop_active)
    else $error("loop entered without a long burst end");

  a_tone_release: assert property (
    (st_r == ST_LOOPED && rel_hit && !manual_s) |=> st_r == ST_DRAIN ##1 !tone_loop_active)
    else $error("release burst did not end loop");

  a_timeout_rel: assert property (
    (st_r == ST_LOOPED && tmo_hit && !rel_hit) |=> st_r == ST_IDLE)
    else $error("timeout did not release loop");

  a_no_timeout: assert property (
    (st_r == ST_LOOPED && !tmo_en_s && !tone_s) |=> st_r == ST_LOOPED)
    else $error("loop left without timeout or tone");

  a_busy_loop: assert property (
    terminal_busy_out |-> loop_active && $past(bo_s))
    else $error("busy shown outside loopback");

  a_short_period: assert property (
    (st_r == ST_LOOPED && tmo_en_s && !long_s && tmo_r >= SHORT_L && !rel_hit)
    |=> st_r == ST_IDLE)
    else $error("short timeout period not honoured");

  a_short_discard: assert property (s_short_burst |=> st_r == ST_IDLE ##1 burst_r <= 1)
    else $error("short burst changed state");

endmodule
`default_nettype wire

//--- rtl/loop_pkg.sv
// Package for the tone loopback controller: timing constants and states.
// Assumes a single 125 MHz system clock; the durations passed to the controller are in ms ticks.
package loop_pkg;

  // Clock and tick base
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  // Tone burst minimum durations, in ms
  localparam int ACT_MIN_MS = 2500;
  localparam int REL_MIN_MS = 1200;

  // Automatic release periods, in minutes, and in ms ticks
  localparam int TMO_SHORT_MIN = 4;
  localparam int TMO_LONG_MIN  = 20;
  localparam int MS_PER_MIN    = 60000;
  localparam int TMO_SHORT_MS  = TMO_SHORT_MIN * MS_PER_MIN;
  localparam int TMO_LONG_MS   = TMO_LONG_MIN * MS_PER_MIN;

  // Counter widths
  localparam int BURST_W = 12;
  localparam int TMO_W   = 21;

  // Tone loop state
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOOPED,
    ST_DRAIN
  } tone_state_type;

endpackage

//--- rtl/tick_divider.sv
// Divider producing a one-cycle enable pulse every CYCLES clocks.
// Assumes it shares the single system clock and reset of its user.
`timescale 1ns/1ns
`default_nettype none
module tick_divider #(
  parameter int CYCLES = 125000
) (
  input  wire logic ref_clk,
  input  wire logic nrst,
  output logic      tick
);

  localparam int CW = $clog2(CYCLES);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          tick_nxt;

  // Count down to zero, then reload and pulse
  always_comb
  begin
    tick_nxt = (cnt_r == '0);
    cnt_nxt  = tick_nxt ? CW'(CYCLES - 1) : cnt_r - 1'b1;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end

endmodule
`default_nettype wire

//--- tb/tone_sender.sv
// Distant test equipment model: drives tone bursts onto the detector line.
// Assumes the bench's shortened tick of TK clocks per ms.
`timescale 1ns/1ns
`default_nettype none
module tone_sender #(
  parameter int TK = 10
) (
  input  wire logic ref_clk,
  output logic      tone_detect
);
  initial tone_detect = 1'b0;
  // Start and stop tone just after a clock edge
  task automatic tone_on;
    @(posedge ref_clk);
    tone_detect <= 1'b1;
  endtask
  task automatic tone_off;
    @(posedge ref_clk);
    tone_detect <= 1'b0;
  endtask
  // Whole burst of n ms
  task automatic burst(input int n);
    tone_on();
    repeat (n * TK) @(posedge ref_clk);
    tone_detect <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Directed tests of manual, tone and timeout loopback behaviour.
// Assumes shortened timing parameters and the tone_sender model.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int TK = 10;
  logic      ref_clk = 1'b0;
  logic      nrst;
  logic      man;
  logic      ext;
  logic      ten;
  logic      tmo;
  logic      lng;
  logic      bsy;
  wire logic tone;
  logic      la;
  logic      tla;
  logic      tbo;
  int        bad_count = 0;
  int        n_checks = 0;
  // Clock at 125 MHz
  always #4 ref_clk = ~ref_clk;
  tone_sender #(.TK(TK)) tone_sender_inst (.ref_clk(ref_clk), .tone_detect(tone));
  tone_loopback_controller #(
    .TICK_CYCLES(TK), .ACT_MS(25), .REL_MS(12), .SHORT_MS(100), .LONG_MS(300)
  ) tone_loopback_controller_inst (
    .ref_clk(ref_clk), .nrst(nrst), .tone_detect(tone),
    .manual_loop_force(man), .external_manual_loop_input(ext),
    .tone_loop_enable(ten), .loop_timeout_enable(tmo),
    .timeout_long_select(lng), .terminal_busy_during_loop(bsy),
    .loop_active(la), .tone_loop_active(tla), .terminal_busy_out(tbo)
  );
  // Compare one output bit
  task automatic chk(input string nm, input logic seen, input logic exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %s exp %b seen %b", nm, exp, seen);
    end
  endtask
  // Wait n ms, then settle past the edge
  task automatic ms(input int n);
    repeat (n * TK) @(posedge ref_clk);
    #1;
  endtask
  // Options: man ext ten tmo lng bsy, each driven on its own
  task automatic put(input logic [5:0] v);
    man <= v[5];
    ext <= v[4];
    ten <= v[3];
    tmo <= v[2];
    lng <= v[1];
    bsy <= v[0];
  endtask
  // Change options just after a rising edge
  task automatic set(input logic [5:0] v);
    @(posedge ref_clk);
    put(v);
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #600000;
    bad_count++;
    tally_and_finish();
  end
  // Test sequence
  initial
  begin
    nrst <= 1'b0;
    put(6'h00);
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    ms(1);
    chk("loop", la, 1'b0);
    set(6'h01);
    tone_sender_inst.burst(30);
    ms(1);
    chk("loop", la, 1'b0);
    chk("tone_loop", tla, 1'b0);
    set(6'h09);
    tone_sender_inst.burst(20);
    ms(2);
    tone_sender_inst.burst(20);
    ms(1);
    chk("loop", la, 1'b0);
    tone_sender_inst.tone_on();
    ms(28);
    chk("loop", la, 1'b0);
    tone_sender_inst.tone_off();
    ms(1);
    chk("loop", la, 1'b1);
    chk("tone_loop", tla, 1'b1);
    chk("busy", tbo, 1'b1);
    ms(300);
    chk("loop", la, 1'b1);
    set(6'h29);
    tone_sender_inst.burst(15);
    ms(1);
    chk("loop", la, 1'b1);
    chk("tone_loop", tla, 1'b1);
    set(6'h09);
    tone_sender_inst.tone_on();
    ms(14);
    chk("loop", la, 1'b0);
    chk("tone_loop", tla, 1'b0);
    chk("busy", tbo, 1'b0);
    tone_sender_inst.tone_off();
    ms(2);
    chk("loop", la, 1'b0);
    set(6'h0d);
    tone_sender_inst.burst(30);
    ms(90);
    chk("loop", la, 1'b1);
    ms(20);
    chk("loop", la, 1'b0);
    chk("tone_loop", tla, 1'b0);
    set(6'h0f);
    tone_sender_inst.burst(30);
    ms(200);
    chk("loop", la, 1'b1);
    ms(110);
    chk("loop", la, 1'b0);
    set(6'h20);
    ms(1);
    chk("loop", la, 1'b1);
    chk("tone_loop", tla, 1'b0);
    chk("busy", tbo, 1'b0);
    set(6'h10);
    ms(1);
    chk("loop", la, 1'b1);
    set(6'h00);
    ms(1);
    chk("loop", la, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
